/* File: src/rfs_pkg.sv */
// Shared constants and types for the ramped FSK sweep engine
package rfs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned FREQ_W  = 48;
  localparam int unsigned RATE_W  = 20;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned MEM_LEN = 32;

  // ----------------------------------------------------------------
  // Byte addresses, first (most significant) byte of each word
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_FIRST_TUNING_WORD  = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_FTW2  = 5'h0a;
  localparam logic [ADDR_W-1:0] ADDR_DELTA = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_RATE  = 5'h1a;
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 5'h1f;

  // ----------------------------------------------------------------
  // Control byte fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_TRI_BIT  = 3;
  localparam int unsigned CTRL_CLRF_BIT = 4;
  localparam int unsigned CTRL_CLRB_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [FREQ_W-1:0] RST_FREQ = 48'h0000_0000_0000;
  localparam logic [RATE_W-1:0] RST_RATE = 20'h00000;

  // Operating modes of the three-bit mode field
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b000,
    MODE_FSK    = 3'b001,
    MODE_RAMP   = 3'b010,
    MODE_CHIRP  = 3'b011,
    MODE_BPSK   = 3'b100
  } rfs_mode_t;

endpackage : rfs_pkg

/* File: src/rfs_rate_if.sv */
// Link between the sweep engine and its ramp-rate counter
`timescale 1ns/100ps
interface rfs_rate_if;
  import rfs_pkg::*;
  logic              ce;
  logic              run;
  logic              restart;
  logic [RATE_W-1:0] rateN;
  logic              tick;

  modport engine  (output ce, output run, output restart, output rateN, input tick);
  modport counter (input ce, input run, input restart, input rateN, output tick);
endinterface : rfs_rate_if

/* File: src/rfs_rate_counter.sv */
// Ramp-rate down-counter: one tick every N+1 clocks while running
`timescale 1ns/100ps
module rfs_rate_counter
  import rfs_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rstSyncN,
  rfs_rate_if.counter  rate
);

  logic [RATE_W-1:0] cnt_q;
  logic [RATE_W-1:0] cnt_d;
  logic              tick_q;
  logic              tick_d;

  // ----------------------------------------------------------------
  // Count down, tick and reload at zero
  // ----------------------------------------------------------------
  // Reloading from the live value lets a new rate apply mid-ramp
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!rate.run || rate.restart) begin
      cnt_d = rate.rateN;
    end else if (cnt_q == '0) begin
      tick_d = 1'b1;
      cnt_d  = rate.rateN;
    end else begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cnt_q  <= RST_RATE;
      tick_q <= 1'b0;
    end else if (rate.ce) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign rate.tick = tick_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tickReload;
    @(posedge clk) disable iff (!rstSyncN || !rate.ce)
      (rate.run && !rate.restart && cnt_q == '0) |=> (tick_q && cnt_q == $past(rate.rateN));
  endproperty
  a_tickReload: assert property (p_tickReload) else $error("No tick or reload at zero");

  property p_tickSpacing;
    @(posedge clk) disable iff (!rstSyncN || !rate.ce)
      (tick_q && rate.run && !rate.restart && rate.rateN == 20'h00001 && $stable(rate.rateN))
        |=> (!tick_q && rate.run && !rate.restart) |=> tick_q;
  endproperty
  a_tickSpacing: assert property (p_tickSpacing) else $error("Tick spacing not N+1");

endmodule : rfs_rate_counter

/* File: src/rfs_sweep_engine.sv */
// Ramped FSK sweep engine: register buffers, frequency and phase accumulators
`timescale 1ns/100ps
module rfs_sweep_engine
  import rfs_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic                      wrEn,
  input  wire logic [rfs_pkg::ADDR_W-1:0] wrAddr,
  input  wire logic [rfs_pkg::BYTE_W-1:0] wrData,
  input  wire logic [rfs_pkg::ADDR_W-1:0] rdAddr,
  output logic      [rfs_pkg::BYTE_W-1:0] rdData_q,
  input  wire logic                      keyingPin,
  input  wire logic                      ioUpdatePin,
  output logic      [rfs_pkg::FREQ_W-1:0] freqWord_q,
  output logic      [rfs_pkg::FREQ_W-1:0] phaseAcc_q,
  output logic                           rampActive_q,
  output logic                           dirUp_q
);
  import rfs_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rstMeta_q;
  logic rstSyncN;
  logic keyMeta_q;
  logic keyS_q;
  logic updMeta_q;
  logic updS_q;
  logic updPrev_q;
  logic updEdge;

  // Reset asserts at once but leaves two clocks after rstn rises
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSyncN  <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN  <= rstMeta_q;
    end
  end

  // Pins are asynchronous; the first stage is never looked at
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      keyMeta_q <= 1'b0;
      keyS_q    <= 1'b0;
      updMeta_q <= 1'b0;
      updS_q    <= 1'b0;
      updPrev_q <= 1'b0;
    end else if (ce) begin
      keyMeta_q <= keyingPin;
      keyS_q    <= keyMeta_q;
      updMeta_q <= ioUpdatePin;
      updS_q    <= updMeta_q;
      updPrev_q <= updS_q;
    end
  end

  assign updEdge = updS_q && !updPrev_q;

  // ----------------------------------------------------------------
  // Buffer and active register bytes
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] bufMem_q [MEM_LEN];
  logic [BYTE_W-1:0] actMem_q [MEM_LEN];

  // One write port into the buffers; core copy only on update edge
  for (genvar i = 0; i < MEM_LEN; i++) begin : g_mem
    logic [BYTE_W-1:0] buf_d;
    logic [BYTE_W-1:0] act_d;
    always_comb begin
      buf_d = bufMem_q[i];
      act_d = actMem_q[i];
      if (wrEn && wrAddr == ADDR_W'(i)) begin
        buf_d = wrData;
      end
      if (updEdge) begin
        act_d = bufMem_q[i];
      end
    end
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        bufMem_q[i] <= RST_BYTE;
        actMem_q[i] <= RST_BYTE;
      end else if (ce) begin
        bufMem_q[i] <= buf_d;
        actMem_q[i] <= act_d;
      end
    end
  end

  // Read back of the buffer bytes
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdData_q <= RST_BYTE;
    end else if (ce) begin
      rdData_q <= bufMem_q[rdAddr];
    end
  end

  // ----------------------------------------------------------------
  // Active fields, most significant byte at the lowest address
  // ----------------------------------------------------------------
  function automatic logic [FREQ_W-1:0] word48(input logic [ADDR_W-1:0] base);
    logic [FREQ_W-1:0] w;
    w = '0;
    for (int b = 0; b < 6; b++) begin
      w = {w[FREQ_W-BYTE_W-1:0], actMem_q[base + ADDR_W'(b)]};
    end
    return w;
  endfunction : word48

  logic [FREQ_W-1:0] lowTone;
  logic [FREQ_W-1:0] highTone;
  logic [FREQ_W-1:0] deltaStep;
  logic [FREQ_W-1:0] span;
  logic [RATE_W-1:0] rateN;
  logic [BYTE_W-1:0] ctrl;
  rfs_mode_t         mode;
  logic              triBit;
  logic              clrBothBit;

  // The function reads the array directly, so only always_comb tracks it
  always_comb begin
    lowTone   = word48(ADDR_FIRST_TUNING_WORD);
    highTone  = word48(ADDR_FTW2);
    deltaStep = word48(ADDR_DELTA);
  end
  assign rateN      = {actMem_q[ADDR_RATE][3:0], actMem_q[ADDR_RATE + 5'h01],
                       actMem_q[ADDR_RATE + 5'h02]};
  assign ctrl       = actMem_q[ADDR_CTRL];
  assign mode       = rfs_mode_t'(ctrl[CTRL_MODE_LSB +: 3]);
  assign triBit     = ctrl[CTRL_TRI_BIT];
  assign clrBothBit = ctrl[CTRL_CLRB_BIT];
  // Host keeps high above low, so the span is never negative
  assign span       = highTone - lowTone;

  // ----------------------------------------------------------------
  // Frequency-clear one-shot
  // ----------------------------------------------------------------
  logic clrShot_q;
  logic clrShot_d;
  logic triPrev_q;
  logic triPrev_d;

  // Fires one clock after each update that carries the clear bit set
  always_comb begin
    clrShot_d = updEdge && bufMem_q[ADDR_CTRL][CTRL_CLRF_BIT];
    triPrev_d = triBit;
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      clrShot_q <= 1'b0;
      triPrev_q <= 1'b0;
    end else if (ce) begin
      clrShot_q <= clrShot_d;
      triPrev_q <= triPrev_d;
    end
  end

  // ----------------------------------------------------------------
  // Ramp-rate counter
  // ----------------------------------------------------------------
  rfs_rate_if rate ();
  logic [FREQ_W-1:0] acc_q;
  logic isRamp;
  logic triRise;
  logic keyTurn;
  logic atDest;

  assign isRamp  = (mode == MODE_RAMP);
  assign triRise = isRamp && triBit && !triPrev_q;
  // A pin level unlike the heading turns the ramp; ignored in triangle
  assign keyTurn = isRamp && !triBit && (keyS_q != dirUp_q);
  assign atDest  = (acc_q >= span);

  assign rate.ce      = ce;
  assign rate.rateN   = rateN;
  assign rate.restart = keyTurn || triRise;
  assign rate.run     = !clrBothBit && ((isRamp && !atDest) ||
                                        (mode == MODE_CHIRP));

  rfs_rate_counter u_rate (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .rate     (rate.counter)
  );

  // ----------------------------------------------------------------
  // Frequency accumulator, output word and phase accumulator
  // ----------------------------------------------------------------
  logic [FREQ_W-1:0] acc_d;
  logic              dirUp_d;
  logic [FREQ_W-1:0] freq_d;
  logic [FREQ_W-1:0] phase_d;
  logic              active_d;
  logic [FREQ_W:0]   sum;

  // The accumulator counts progress from the start tone to the target
  always_comb begin
    acc_d    = acc_q;
    dirUp_d  = dirUp_q;
    sum      = {1'b0, acc_q} + {1'b0, deltaStep};
    phase_d  = phaseAcc_q + freqWord_q;
    if (clrBothBit) begin
      acc_d   = '0;
      phase_d = '0;
    end else if (isRamp) begin
      if (triRise) begin
        dirUp_d = !keyS_q;
        acc_d   = '0;
      end else if (keyTurn) begin
        // Mirror the progress so the tone carries on without a jump
        dirUp_d = keyS_q;
        acc_d   = atDest ? '0 : span - acc_q;
      end else if (clrShot_q) begin
        acc_d   = '0;
      end else if (rate.tick && !atDest) begin
        acc_d   = (sum >= {1'b0, span}) ? span : sum[FREQ_W-1:0];
      end else if (triBit && atDest) begin
        dirUp_d = !dirUp_q;
        acc_d   = '0;
      end
    end else if (mode == MODE_CHIRP) begin
      if (clrShot_q) begin
        acc_d = '0;
      end else if (rate.tick) begin
        acc_d = sum[FREQ_W-1:0];
      end
    end else begin
      acc_d   = '0;
      dirUp_d = keyS_q;
    end
  end

  // Output tone chosen by mode; ramp adds to low or takes from high
  always_comb begin
    case (mode)
      MODE_FSK:   freq_d = keyS_q ? highTone : lowTone;
      MODE_RAMP:  freq_d = dirUp_d ? lowTone + acc_d : highTone - acc_d;
      MODE_CHIRP: freq_d = lowTone + acc_d;
      default:    freq_d = lowTone;
    endcase
    if (clrBothBit) begin
      freq_d = '0;
    end
    active_d = rate.run;
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      acc_q        <= RST_FREQ;
      dirUp_q      <= 1'b0;
      freqWord_q   <= RST_FREQ;
      phaseAcc_q   <= RST_FREQ;
      rampActive_q <= 1'b0;
    end else if (ce) begin
      acc_q        <= acc_d;
      dirUp_q      <= dirUp_d;
      freqWord_q   <= freq_d;
      phaseAcc_q   <= phase_d;
      rampActive_q <= active_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_updateSeen;
    updEdge ##1 1'b1;
  endsequence

  property p_update;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      s_updateSeen |-> actMem_q[ADDR_CTRL] == $past(bufMem_q[ADDR_CTRL]);
  endproperty
  a_update: assert property (p_update) else $error("Update did not copy buffer");

  property p_clrBoth;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      clrBothBit |=> (acc_q == '0 && phaseAcc_q == '0 && freqWord_q == '0);
  endproperty
  a_clrBoth: assert property (p_clrBoth) else $error("Both-clear not holding zero");

  property p_oneShot;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      clrShot_q |=> !clrShot_q;
  endproperty
  a_oneShot: assert property (p_oneShot) else $error("Clear one-shot wider than a clock");

  property p_clrRestart;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      (clrShot_q && isRamp && !clrBothBit && !triRise && !keyTurn) |=> acc_q == '0;
  endproperty
  a_clrRestart: assert property (p_clrRestart) else $error("Clear did not restart");

  property p_noOvershoot;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      (isRamp && rate.tick && !clrBothBit && !triRise && !keyTurn && !clrShot_q
       && !updEdge) |=> (acc_q <= span);
  endproperty
  a_noOvershoot: assert property (p_noOvershoot) else $error("Ramp overshot target");

  property p_dwell;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      (isRamp && !triBit && acc_q == span && !keyTurn && !clrShot_q && !clrBothBit
       && !updEdge) |=> ($stable(acc_q) && !rampActive_q);
  endproperty
  a_dwell: assert property (p_dwell) else $error("Left destination while pin steady");

  property p_reverse;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      (keyTurn && !clrBothBit && !triRise) |=> dirUp_q == $past(keyS_q);
  endproperty
  a_reverse: assert property (p_reverse) else $error("Ramp did not reverse");

  property p_triStart;
    @(posedge clk) disable iff (!rstSyncN || !ce)
      (triRise && !clrBothBit) |=> (acc_q == '0 && dirUp_q == !$past(keyS_q));
  endproperty
  a_triStart: assert property (p_triStart) else $error("Triangle start tone wrong");

endmodule : rfs_sweep_engine

/* File: sim/rfs_host_model.sv */
// Host model: register byte writes, update pulses and keying pin
`timescale 1ns/100ps
module rfs_host_model
  import rfs_pkg::*;
(
  input  wire logic                       clk,
  output logic                            wrEn,
  output logic      [rfs_pkg::ADDR_W-1:0] wrAddr,
  output logic      [rfs_pkg::BYTE_W-1:0] wrData,
  output logic                            keyingPin,
  output logic                            ioUpdatePin
);
  // Idle levels before the first request
  initial begin
    wrEn        = 1'b0;
    wrAddr      = 5'h00;
    wrData      = 8'h00;
    keyingPin   = 1'b0;
    ioUpdatePin = 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte writes, one per clock, big-endian words
  // ----------------------------------------------------------------
  task automatic putByte(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(posedge clk);
    #1;
    wrEn   = 1'b1;
    wrAddr = a;
    wrData = d;
  endtask : putByte

  // Released lines show inverted junk, not the last byte
  task automatic releaseBus();
    @(posedge clk);
    #1;
    wrEn   = 1'b0;
    wrAddr = ~wrAddr;
    wrData = ~wrData;
  endtask : releaseBus

  task automatic wr8(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    putByte(a, d);
    releaseBus();
  endtask : wr8

  task automatic wr48(input logic [ADDR_W-1:0] a, input logic [FREQ_W-1:0] v);
    for (int i = 0; i < 6; i++) putByte(a + ADDR_W'(i), v[47-8*i -: 8]);
    releaseBus();
  endtask : wr48

  task automatic wr24(input logic [ADDR_W-1:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) putByte(a + ADDR_W'(i), v[23-8*i -: 8]);
    releaseBus();
  endtask : wr24

  // Pulse held 3 clocks high and low so the synchroniser sees it
  task automatic update();
    @(posedge clk);
    #1;
    ioUpdatePin = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    ioUpdatePin = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : update

  task automatic key(input logic v);
    @(posedge clk);
    #1;
    keyingPin = v;
  endtask : key

  // Tones low then high, positive step, nonzero rate
  task automatic setRamp(input logic [FREQ_W-1:0] lo, input logic [FREQ_W-1:0] hi,
                         input logic [FREQ_W-1:0] dl, input logic [RATE_W-1:0] n);
    wr48(ADDR_FIRST_TUNING_WORD, lo);
    wr48(ADDR_FTW2, hi);
    wr48(ADDR_DELTA, {1'b0, dl[46:0]});
    wr24(ADDR_RATE, {4'h0, (n == 20'h00000) ? 20'h00001 : n});
  endtask : setRamp

  // Control byte write followed by an update
  task automatic ctrl(input rfs_mode_t m, input logic sweep, input logic clrF, input logic clrB);
    logic [BYTE_W-1:0] b;
    b = RST_BYTE;
    b[CTRL_MODE_LSB +: 3] = m;
    b[CTRL_TRI_BIT]       = sweep;
    b[CTRL_CLRF_BIT]      = clrF;
    b[CTRL_CLRB_BIT]      = clrB;
    wr8(ADDR_CTRL, b);
    update();
  endtask : ctrl
endmodule : rfs_host_model

/* File: sim/tb.sv */
// Self-checking testbench of the ramped FSK sweep engine
`timescale 1ns/100ps
module tb;
  import rfs_pkg::*;
  localparam logic [FREQ_W-1:0] LOW   = 48'h0000_0100_0000;
  localparam logic [FREQ_W-1:0] SPAN  = 48'h0000_0000_03c0;
  localparam logic [FREQ_W-1:0] HIGH  = LOW + SPAN;
  localparam logic [FREQ_W-1:0] DELTA = 48'h0000_0000_0100;
  localparam logic [FREQ_W-1:0] DEL2  = 48'h0000_0000_0040;
  localparam logic [RATE_W-1:0] RATE  = 20'h00013;
  localparam logic [RATE_W-1:0] RATE2 = 20'h00009;
  typedef struct {logic [ADDR_W-1:0] a; logic [BYTE_W-1:0] d;} rfs_row_t;
  rfs_row_t rows [8] = '{'{5'h04, 8'h5a}, '{5'h09, 8'ha5}, '{5'h0a, 8'h3c}, '{5'h0f, 8'hc3},
                         '{5'h10, 8'h81}, '{5'h15, 8'h7e}, '{5'h1a, 8'h0f}, '{5'h1c, 8'hf0}};
  logic              clk;
  logic              rstn;
  logic              ce;
  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [BYTE_W-1:0] wrData;
  logic [ADDR_W-1:0] rdAddr;
  logic [BYTE_W-1:0] rdData_q;
  logic              keyingPin;
  logic              ioUpdatePin;
  logic [FREQ_W-1:0] freqWord_q;
  logic [FREQ_W-1:0] phaseAcc_q;
  logic              rampActive_q;
  logic              dirUp_q;
  logic [BYTE_W-1:0] b;
  logic [FREQ_W-1:0] f;
  logic [FREQ_W-1:0] p;
  int                err_count;
  int                check_count;

  // Free-running 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  rfs_sweep_engine i_rfs_sweep_engine (
    .clk(clk), .rstn(rstn), .ce(ce), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .rdAddr(rdAddr), .rdData_q(rdData_q), .keyingPin(keyingPin),
    .ioUpdatePin(ioUpdatePin), .freqWord_q(freqWord_q), .phaseAcc_q(phaseAcc_q),
    .rampActive_q(rampActive_q), .dirUp_q(dirUp_q));

  rfs_host_model i_rfs_host_model (
    .clk(clk), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .keyingPin(keyingPin), .ioUpdatePin(ioUpdatePin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [FREQ_W-1:0] s, input logic [FREQ_W-1:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] d);
    cyc(1);
    rdAddr = a;
    cyc(1);
    d = rdData_q;
  endtask : rd

  // Bounded waits; running out counts as a mismatch
  task automatic settle();
    int n = 0;
    while (rampActive_q !== 1'b0 && n < 600) begin cyc(1); n++; end
    chk("settleInTime", 48'(n < 600), 48'h1);
  endtask : settle

  task automatic waitDir(input logic v);
    int n = 0;
    while (dirUp_q !== v && n < 600) begin cyc(1); n++; end
    chk("turnInTime", 48'(n < 600), 48'h1);
  endtask : waitDir

  // Follows ramp steps: spacing N+1 clocks, no step above delta
  task automatic watch(input int steps, input logic [RATE_W-1:0] n, input logic [FREQ_W-1:0] d);
    logic [FREQ_W-1:0] prev;
    int                gap;
    prev = freqWord_q;
    for (int i = 0; i < steps; i++) begin
      gap = 0;
      while (freqWord_q === prev && gap < 100) begin cyc(1); gap++; end
      if (i > 0) chk("stepGap", 48'(gap), 48'(n) + 48'h1);
      chk("stepSize", 48'((freqWord_q > prev ? freqWord_q - prev : prev - freqWord_q) <= d),
          48'h1);
      prev = freqWord_q;
    end
  endtask : watch

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Watchdog at 10000 clocks, well beyond the expected run of under two thousand clocks
  initial begin
    #200us;
    err_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_count   = 0;
    check_count = 0;
    rstn   = 1'b0;
    ce     = 1'b1;
    rdAddr = 5'h00;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    cyc(3);
    chk("freqWordRst", freqWord_q, RST_FREQ);
    rd(ADDR_RATE, b);
    chk("rateByteRst", 48'(b), 48'(RST_BYTE));
    $display("test reset done");
    // Write then read back each table row
    foreach (rows[i]) begin
      i_rfs_host_model.wr8(rows[i].a, rows[i].d);
      rd(rows[i].a, b);
      chk("bufferByte", 48'(b), 48'(rows[i].d));
    end
    $display("test register table done");
    // Clear toggled low-high-low, ramp settles at the low tone
    i_rfs_host_model.setRamp(LOW, HIGH, DELTA, RATE);
    i_rfs_host_model.ctrl(MODE_RAMP, 1'b0, 1'b1, 1'b0);
    i_rfs_host_model.ctrl(MODE_RAMP, 1'b0, 1'b0, 1'b0);
    settle();
    chk("freqAtLow", freqWord_q, LOW);
    i_rfs_host_model.key(1'b1);
    watch(4, RATE, DELTA);
    settle();
    chk("freqAtHigh", freqWord_q, HIGH);
    chk("dirUp", 48'(dirUp_q), 48'h1);
    cyc(30);
    chk("dwellHigh", freqWord_q, HIGH);
    p = phaseAcc_q;
    f = freqWord_q;
    cyc(1);
    chk("phaseStep", phaseAcc_q - p, f);
    // Clock enable low freezes every register but the reset synchroniser
    ce = 1'b0;
    p = phaseAcc_q;
    cyc(5);
    chk("ceFreeze", phaseAcc_q, p);
    ce = 1'b1;
    $display("test ramp up done");
    // Held clear bit refires on each update, also at destination
    for (int k = 0; k < 2; k++) begin
      i_rfs_host_model.ctrl(MODE_RAMP, 1'b0, 1'b1, 1'b0);
      chk("clearRestart", 48'(freqWord_q <= LOW + DELTA), 48'h1);
      settle();
      chk("clearResume", freqWord_q, HIGH);
    end
    i_rfs_host_model.ctrl(MODE_RAMP, 1'b0, 1'b0, 1'b0);
    $display("test clear one-shot done");
    // Slope changed mid-ramp, then an early reversal
    i_rfs_host_model.key(1'b0);
    watch(1, RATE, DELTA);
    i_rfs_host_model.wr48(ADDR_DELTA, DEL2);
    i_rfs_host_model.wr24(ADDR_RATE, {4'h0, RATE2});
    i_rfs_host_model.update();
    watch(3, RATE2, DEL2);
    f = freqWord_q;
    i_rfs_host_model.key(1'b1);
    watch(1, RATE2, DEL2);
    chk("reversedUp", 48'(freqWord_q > f), 48'h1);
    settle();
    chk("reversalEnd", freqWord_q, HIGH);
    $display("test reversal done");
    // Triangle from the high tone; the pin no longer matters
    i_rfs_host_model.ctrl(MODE_RAMP, 1'b1, 1'b0, 1'b0);
    chk("triStartDown", 48'(dirUp_q), 48'h0);
    i_rfs_host_model.key(1'b0);
    waitDir(1'b1);
    chk("triTurnLow", 48'(freqWord_q < LOW + DELTA), 48'h1);
    waitDir(1'b0);
    chk("triTurnHigh", 48'(freqWord_q > HIGH - DELTA), 48'h1);
    $display("test triangle done");
    // Both-clear holds zero output until dropped
    i_rfs_host_model.ctrl(MODE_RAMP, 1'b0, 1'b0, 1'b1);
    chk("bothClrFreq", freqWord_q, RST_FREQ);
    cyc(10);
    chk("bothClrPhase", phaseAcc_q, RST_FREQ);
    i_rfs_host_model.ctrl(MODE_RAMP, 1'b0, 1'b0, 1'b0);
    cyc(10);
    chk("phaseResumes", 48'(phaseAcc_q !== RST_FREQ), 48'h1);
    $display("test both clear done");
    // Chirp keeps going past the high tone
    i_rfs_host_model.key(1'b1);
    i_rfs_host_model.ctrl(MODE_CHIRP, 1'b0, 1'b0, 1'b0);
    cyc(300);
    chk("chirpPastHigh", 48'(freqWord_q > HIGH), 48'h1);
    chk("chirpRunning", 48'(rampActive_q), 48'h1);
    // Shortest allowed rate: one step every second clock
    i_rfs_host_model.wr24(ADDR_RATE, 24'h000001);
    i_rfs_host_model.update();
    watch(3, 20'h00001, DEL2);
    $display("test chirp done");
    // Plain keying mode jumps straight between the tones
    i_rfs_host_model.ctrl(MODE_FSK, 1'b0, 1'b0, 1'b0);
    chk("fskHigh", freqWord_q, HIGH);
    i_rfs_host_model.key(1'b0);
    cyc(4);
    chk("fskLow", freqWord_q, LOW);
    $display("test keying done");
    // Reset in mid-run clears at once and leaves through the synchroniser
    rstn = 1'b0;
    cyc(1);
    chk("midRstFreq", freqWord_q, RST_FREQ);
    chk("midRstPhase", phaseAcc_q, RST_FREQ);
    rstn = 1'b1;
    cyc(3);
    chk("midRstActive", 48'(rampActive_q), 48'h0);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb
